// ===== common/aps_pkg.sv
package aps_pkg;
   // Register byte addresses on the serial control bus.
   localparam logic [7:0] ADDR_INT_CTRL    = 8'h81;
   localparam logic [7:0] ADDR_PATH_CFG    = 8'hD0;
   localparam logic [7:0] ADDR_PCM_OUT     = 8'hD6;
   localparam logic [7:0] ADDR_FEED        = 8'hD8;
   localparam logic [7:0] ADDR_PCM_IN      = 8'hD9;
   localparam logic [7:0] ADDR_READBACK    = 8'hDA;
   // Field positions in decoder_path_config.
   localparam int         BIT_RATE4        = 15;
   localparam int         BIT_PCM_SEL_HI   = 14;
   localparam int         BIT_ADM_SEL_HI   = 12;
   localparam int         BIT_OUT_SEL_HI   = 10;
   // Decoder enable in the interrupt control register.
   localparam int         BIT_DEC_EN       = 3;
   // Reset values.
   localparam logic [15:0] RST_PATH_CFG    = 16'h0000;
   localparam logic [7:0]  RST_INT_CTRL    = 8'h00;
   localparam logic [15:0] RST_WORD        = 16'h0000;
   // Rate factors, as last phase index.
   localparam logic [2:0] LAST_PHASE_4     = 3'h3;
   localparam logic [2:0] LAST_PHASE_8     = 3'h7;
   // Companding expansion constants.
   localparam logic [7:0]  MU_BIAS         = 8'h84;
   localparam logic [7:0]  A_TOGGLE        = 8'h55;

   typedef enum logic [1:0] {
      APS_OUT_EST  = 2'b00,
      APS_OUT_SUM  = 2'b01,
      APS_OUT_TEST = 2'b10,
      APS_OUT_UND  = 2'b11
   } aps_out_sel_t;

   typedef struct packed {
      logic         rate4;
      logic [1:0]   pcm_sel;
      logic [1:0]   adm_sel;
      aps_out_sel_t out_sel;
   } aps_cfg_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } aps_reg_req_t;

   typedef struct packed {
      logic       alaw;
      logic [7:0] code;
   } aps_burst_t;
endpackage : aps_pkg

// ===== rtl/aps_decoder_path.sv
// What this block does
// R01: Rate filter interpolates toward DAC for PCM, decimates for delta bits.
// R02: Rate bit 1 gives factor 4, 0 gives factor 8.
// R03: Decimated PCM samples land in the PCM output register each sample.
// R04: Transcoded bits land in the readback register at interpolated rate.
// R05: PCM select upper bit 0 decimates the estimator output.
// R06: PCM select 1,0 interpolates burst pin PCM; host sets codec mode too.
// R07: Burst mu-law or A-law samples are expanded to linear first.
// R08: PCM select 1,1 interpolates host-written PCM input words.
// R09: ADM select 0,0 takes decoder bits from the received data pin.
// R10: ADM select 0,1 takes decoder bits from the host feed register.
// R11: ADM select upper bit 1 uses digital feedback; host sets interpolate.
// R12: Host may power down analog side during digital feedback transcoding.
// R13: Output select 0,0 drives estimator output alone.
// R14: Output select 0,1 drives estimator plus interpolated PCM sum.
// R15: Output select 1,0 is direct PCM test mode.
// R16: Decoder enable bit low holds decoder disabled and in reset.
// R17: Output select 1,1 behaves as 0,0.
// R18: Path selections switch only at decoder sample boundaries or while the decoder is held in reset.
`timescale 1ns/1ps
`default_nettype none

module aps_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("aps_fifo: DEPTH must be a power of two of at least 2");
   end

   // Ready stays low while the datapath is held in reset, since a byte
   // offered then would be dropped without trace.
   assign in_ready_out  = ~rst_in & (count_r != (AW+1)'(DEPTH));
   assign out_valid_out = (count_r != '0);
   assign out_data_out  = mem_r[rd_ptr_r];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_ready_in & out_valid_out;

   always_ff @(posedge clk_in)
   begin
      if (push)
         mem_r[wr_ptr_r] <= in_data_in;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= rd_ptr_r + 1'b1;
         if (push & ~pop)
            count_r <= count_r + 1'b1;
         else if (pop & ~push)
            count_r <= count_r - 1'b1;
      end
   end
endmodule : aps_fifo

module aps_decoder_path #(
   parameter logic [15:0] STEP_SIZE  = 16'h0100,
   parameter int          FIFO_DEPTH = 4
) (
   // Clock and reset.
   input  wire logic                  CLK_IN,
   input  wire logic                  SYS_RST_IN,
   // Host control bus.
   input  wire aps_pkg::aps_reg_req_t REG_REQ_IN,
   output logic               [15:0]  REG_RDATA_OUT,
   // Received link.
   input  wire logic                  BIT_STB_IN,
   input  wire logic                  RX_DATA_IN,
   input  wire logic                  BURST_VALID_IN,
   output logic                       BURST_READY_OUT,
   input  wire aps_pkg::aps_burst_t   BURST_IN,
   // DAC side.
   output logic               [15:0]  DAC_DATA_OUT,
   output logic                       DAC_VALID_OUT
);
   aps_pkg::aps_cfg_t cfg_reg;
   aps_pkg::aps_cfg_t act_r;
   logic [15:0]        path_cfg_r;
   logic [7:0]         int_ctrl_r;
   logic [15:0]        feed_r;
   logic [15:0]        host_pcm_r;
   logic [15:0]        pcm_out_r;
   logic [15:0]        readback_r;
   logic [7:0]         bits_sh_r;
   logic [3:0]         feed_idx_r;
   logic [2:0]         phase_r;
   logic signed [15:0] est_r;
   logic signed [15:0] interp_r;
   logic signed [18:0] acc_r;
   logic               dp_rst;
   logic               boundary;
   logic               adm_bit;
   logic signed [15:0] est_nxt;
   logic signed [18:0] acc_nxt;
   logic signed [15:0] dac_nxt;
   logic [15:0]        expanded;
   logic               fifo_valid;
   logic [15:0]        fifo_data;
   logic               fifo_pop;
   logic               interp_mode;

   initial
   begin
      if (FIFO_DEPTH < 2)
         $error("aps_decoder_path: FIFO_DEPTH must be at least 2");
   end

   // Saturating 17-bit to 16-bit clamp.
   function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
      if (v > 17'sh07FFF)
         sat16 = 16'sh7FFF;
      else if (v < -17'sh08000)
         sat16 = -16'sh8000;
      else
         sat16 = v[15:0];
   endfunction : sat16

   // Companded byte to 16-bit linear, left justified.
   function automatic logic [15:0] expand(input aps_pkg::aps_burst_t b);
      logic [7:0]  c;
      logic [2:0]  ex;
      logic [14:0] mag;
      logic        neg;
      c   = b.alaw ? (b.code ^ aps_pkg::A_TOGGLE) : ~b.code;
      ex  = c[6:4];
      neg = b.alaw ? ~c[7] : c[7];
      if (b.alaw)
      begin
         if (ex == 3'h0)
            mag = {7'h00, c[3:0], 4'h8};
         else
            mag = 15'(({7'h00, c[3:0], 4'h0} + 15'h0108) << (ex - 3'h1));
      end
      else
         mag = 15'((({7'h00, c[3:0], 3'h0} + 15'(aps_pkg::MU_BIAS))
               << ex) - 15'(aps_pkg::MU_BIAS));
      expand = neg ? 16'(-{1'b0, mag}) : {1'b0, mag};
   endfunction : expand

   assign cfg_reg.rate4   = path_cfg_r[aps_pkg::BIT_RATE4];
   assign cfg_reg.pcm_sel =
      path_cfg_r[aps_pkg::BIT_PCM_SEL_HI -: 2];
   assign cfg_reg.adm_sel =
      path_cfg_r[aps_pkg::BIT_ADM_SEL_HI -: 2];
   assign cfg_reg.out_sel = aps_pkg::aps_out_sel_t'(
      path_cfg_r[aps_pkg::BIT_OUT_SEL_HI -: 2]);

   assign dp_rst = SYS_RST_IN | ~int_ctrl_r[aps_pkg::BIT_DEC_EN]; // [R16]

   assign boundary = BIT_STB_IN & (phase_r == (act_r.rate4 ?
      aps_pkg::LAST_PHASE_4 : aps_pkg::LAST_PHASE_8)); // [R02]

   assign interp_mode = act_r.pcm_sel[1]; // [R01] [R05]
   assign fifo_pop    = boundary & (act_r.pcm_sel == 2'b10);

   always_ff @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         path_cfg_r <= aps_pkg::RST_PATH_CFG;
         int_ctrl_r <= aps_pkg::RST_INT_CTRL;
         feed_r     <= aps_pkg::RST_WORD;
         host_pcm_r <= aps_pkg::RST_WORD;
      end
      else if (REG_REQ_IN.wr)
      begin
         unique case (REG_REQ_IN.addr)
            aps_pkg::ADDR_PATH_CFG: path_cfg_r <= REG_REQ_IN.wdata;
            aps_pkg::ADDR_INT_CTRL: int_ctrl_r <= REG_REQ_IN.wdata[7:0];
            aps_pkg::ADDR_FEED:     feed_r     <= REG_REQ_IN.wdata;
            aps_pkg::ADDR_PCM_IN:   host_pcm_r <= REG_REQ_IN.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
         REG_RDATA_OUT <= aps_pkg::RST_WORD;
      else if (REG_REQ_IN.rd)
      begin
         unique case (REG_REQ_IN.addr)
            aps_pkg::ADDR_PATH_CFG: REG_RDATA_OUT <= path_cfg_r;
            aps_pkg::ADDR_INT_CTRL: REG_RDATA_OUT <= {8'h00, int_ctrl_r};
            aps_pkg::ADDR_PCM_OUT:  REG_RDATA_OUT <= pcm_out_r;
            aps_pkg::ADDR_FEED:     REG_RDATA_OUT <= feed_r;
            aps_pkg::ADDR_PCM_IN:   REG_RDATA_OUT <= host_pcm_r;
            aps_pkg::ADDR_READBACK: REG_RDATA_OUT <= readback_r;
            default:                REG_RDATA_OUT <= 16'h0000;
         endcase
      end
   end

   // The active copy only moves on a sample boundary or while the decoder
   // is held in reset, so a host write in mid-sample never feeds the filter
   // a half-switched source.
   always_ff @(posedge CLK_IN)
   begin
      if (dp_rst)
      begin
         act_r   <= cfg_reg;
         phase_r <= 3'h0;
      end
      else if (BIT_STB_IN)
      begin
         if (boundary)
         begin
            act_r   <= cfg_reg; // [R18]
            phase_r <= 3'h0;
         end
         else
            phase_r <= phase_r + 3'h1;
      end
   end

   always_comb
   begin
      unique case (act_r.adm_sel)
         2'b00:   adm_bit = RX_DATA_IN; // [R09]
         2'b01:   adm_bit = feed_r[feed_idx_r]; // [R10]
         default: adm_bit = (interp_r > est_r); // [R11]
      endcase
   end

   assign est_nxt = adm_bit ? sat16(17'(est_r) + 17'(signed'(STEP_SIZE)))
                            : sat16(17'(est_r) - 17'(signed'(STEP_SIZE)));
   assign acc_nxt = acc_r + 19'(est_nxt);

   always_comb
   begin
      unique case (act_r.out_sel)
         aps_pkg::APS_OUT_SUM:
            dac_nxt = sat16(17'(est_nxt) + 17'(interp_r)); // [R14]
         // The filter here is a zero-order hold, so the held input word
         // is also the unfiltered word shown in test mode.
         aps_pkg::APS_OUT_TEST: dac_nxt = interp_r; // [R15]
         default:               dac_nxt = est_nxt; // [R13] [R17]
      endcase
   end

   always_ff @(posedge CLK_IN)
   begin
      if (dp_rst)
      begin
         est_r      <= '0;
         feed_idx_r <= 4'hF;
         bits_sh_r  <= 8'h00;
      end
      else if (BIT_STB_IN)
      begin
         est_r      <= est_nxt;
         feed_idx_r <= feed_idx_r - 4'h1;
         bits_sh_r  <= {bits_sh_r[6:0], adm_bit};
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (dp_rst)
      begin
         acc_r     <= '0;
         pcm_out_r <= aps_pkg::RST_WORD;
      end
      else if (BIT_STB_IN)
      begin
         if (boundary)
         begin
            acc_r <= '0;
            if (!interp_mode)
               pcm_out_r <= act_r.rate4 ? 16'(acc_nxt >>> 2)
                                        : 16'(acc_nxt >>> 3); // [R03] [R05]
         end
         else
            acc_r <= acc_nxt;
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (dp_rst)
      begin
         interp_r   <= '0;
         readback_r <= aps_pkg::RST_WORD;
      end
      else if (boundary && interp_mode)
      begin
         if (act_r.pcm_sel[0])
            interp_r <= host_pcm_r; // [R08]
         else if (fifo_valid)
            interp_r <= fifo_data; // [R06]
         if (act_r.adm_sel[1])
            readback_r <= act_r.rate4 ?
               {12'h000, bits_sh_r[2:0], adm_bit} :
               {8'h00, bits_sh_r[6:0], adm_bit}; // [R04]
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (dp_rst)
      begin
         DAC_DATA_OUT  <= aps_pkg::RST_WORD;
         DAC_VALID_OUT <= 1'b0;
      end
      else
      begin
         DAC_VALID_OUT <= BIT_STB_IN;
         if (BIT_STB_IN)
            DAC_DATA_OUT <= dac_nxt;
      end
   end

   assign expanded = expand(BURST_IN); // [R07]

   aps_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_burst_fifo (
      .clk_in        (CLK_IN),
      .rst_in        (dp_rst),
      .in_valid_in   (BURST_VALID_IN),
      .in_ready_out  (BURST_READY_OUT),
      .in_data_in    (expanded),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_pop),
      .out_data_out  (fifo_data)
   );
endmodule : aps_decoder_path

`default_nettype wire

// ===== bench/aps_decoder_path_properties.sv
`timescale 1ns/1ps
`default_nettype none
module aps_decoder_path_chk #(
   parameter logic [15:0] STEP_SIZE  = 16'h0100,
   parameter int          FIFO_DEPTH = 4
) (
   // Clock and reset.
   input wire logic                  CLK_IN,
   input wire logic                  SYS_RST_IN,
   // Host and link side.
   input wire aps_pkg::aps_reg_req_t REG_REQ_IN,
   input wire logic [15:0]           REG_RDATA_OUT,
   input wire logic                  BIT_STB_IN,
   input wire logic                  RX_DATA_IN,
   input wire logic                  BURST_VALID_IN,
   input wire logic                  BURST_READY_OUT,
   input wire aps_pkg::aps_burst_t   BURST_IN,
   // DAC side.
   input wire logic [15:0]           DAC_DATA_OUT,
   input wire logic                  DAC_VALID_OUT
);
   logic [15:0] cfg_r;
   logic [7:0]  ctl_r;
   logic        en_q_r;
   logic        en;
   logic        rd_only;
   assign en      = ctl_r[aps_pkg::BIT_DEC_EN];
   assign rd_only = REG_REQ_IN.rd && !REG_REQ_IN.wr;
   // Shadow of host writes; en_q_r lets enable edges settle for a cycle.
   always_ff @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         cfg_r  <= aps_pkg::RST_PATH_CFG;
         ctl_r  <= aps_pkg::RST_INT_CTRL;
         en_q_r <= 1'b0;
      end
      else
      begin
         if (REG_REQ_IN.wr && REG_REQ_IN.addr == aps_pkg::ADDR_PATH_CFG)
            cfg_r <= REG_REQ_IN.wdata;
         if (REG_REQ_IN.wr && REG_REQ_IN.addr == aps_pkg::ADDR_INT_CTRL)
            ctl_r <= REG_REQ_IN.wdata[7:0];
         en_q_r <= en;
      end
   end
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (SYS_RST_IN);
   valid_cause_a: assert property (
      DAC_VALID_OUT |-> $past(BIT_STB_IN)) else $error("valid without strobe");
   strobe_valid_a: assert property (
      BIT_STB_IN && en && en_q_r |=> DAC_VALID_OUT) else $error("no valid");
   est_step_a: assert property (
      DAC_VALID_OUT && en_q_r && cfg_r[12:11] == 2'b00 && cfg_r[10] == cfg_r[9]
      |-> DAC_DATA_OUT == $past(DAC_DATA_OUT)
          + ($past(RX_DATA_IN) ? STEP_SIZE : -STEP_SIZE))
      else $error("estimator step wrong");
   dac_hold_a: assert property (
      !$past(BIT_STB_IN) && en && en_q_r |-> $stable(DAC_DATA_OUT))
      else $error("DAC moved without strobe");
   off_quiet_a: assert property (
      !en && !en_q_r |-> DAC_DATA_OUT == 16'h0000 && !DAC_VALID_OUT
      && !BURST_READY_OUT) else $error("decoder active while disabled");
   cfg_read_a: assert property (
      rd_only && REG_REQ_IN.addr == aps_pkg::ADDR_PATH_CFG
      |=> REG_RDATA_OUT == $past(cfg_r)) else $error("config read wrong");
   ctl_read_a: assert property (
      rd_only && REG_REQ_IN.addr == aps_pkg::ADDR_INT_CTRL
      |=> REG_RDATA_OUT == {8'h00, $past(ctl_r)}) else $error("ctrl read");
   rb_width_a: assert property (
      rd_only && REG_REQ_IN.addr == aps_pkg::ADDR_READBACK
      |=> (REG_RDATA_OUT >> ($past(cfg_r[15]) ? 4 : 8)) == 16'h0000)
      else $error("readback too wide");
   rd_hold_a: assert property (
      !$past(REG_REQ_IN.rd) |-> $stable(REG_RDATA_OUT))
      else $error("read data moved");
   cover property (DAC_VALID_OUT && en_q_r && cfg_r[10:9] == 2'b01);
   cover property (BURST_VALID_IN && BURST_READY_OUT);
   cover property (!BURST_READY_OUT && en && en_q_r);
endmodule : aps_decoder_path_chk
bind aps_decoder_path aps_decoder_path_chk #(
   .STEP_SIZE (STEP_SIZE),
   .FIFO_DEPTH(FIFO_DEPTH)
) u_chk (
   .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .REG_REQ_IN(REG_REQ_IN),
   .REG_RDATA_OUT(REG_RDATA_OUT), .BIT_STB_IN(BIT_STB_IN),
   .RX_DATA_IN(RX_DATA_IN), .BURST_VALID_IN(BURST_VALID_IN),
   .BURST_READY_OUT(BURST_READY_OUT), .BURST_IN(BURST_IN),
   .DAC_DATA_OUT(DAC_DATA_OUT), .DAC_VALID_OUT(DAC_VALID_OUT)
);
`default_nettype wire

// ===== bench/aps_burst_src.sv
`timescale 1ns/1ps
`default_nettype none
// Idle data inverts every clock, so the last byte reappears only on alternate idle cycles.
module aps_burst_src (
   input  wire logic           clk_in,
   input  wire logic           ready_in,
   output logic                valid_out,
   output aps_pkg::aps_burst_t data_out
);
   aps_pkg::aps_burst_t q[$];
   initial
   begin
      valid_out = 1'b0;
      data_out  = '0;
   end
   always @(posedge clk_in)
   begin
      if (valid_out && ready_in)
         void'(q.pop_front());
      valid_out <= q.size() != 0;
      data_out  <= q.size() != 0 ? q[0] : ~data_out;
   end
endmodule : aps_burst_src
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [15:0] STEP = 16'h0100;
   localparam logic [15:0] FW   = 16'hA5C3;
   // Feedback bits expected while the estimator tracks 0 and then 0x0300.
   localparam logic [7:0]  FBK  = 8'h7A;
   logic                  clk  = 1'b0;
   logic                  rst  = 1'b1;
   logic                  stb  = 1'b0;
   logic                  rx   = 1'b0;
   logic                  seen = 1'b0;
   logic                  b;
   aps_pkg::aps_reg_req_t req  = '0;
   aps_pkg::aps_burst_t   bdat;
   logic                  bval, brdy, dval;
   logic [15:0]           rdata, dac;
   logic [15:0]           est  = 16'h0000;
   logic [15:0]           dq[$];
   logic [15:0]           rq[$];
   int                    bad_count = 0;
   int                    check_count = 0;
   logic [15:0] lin[5] = '{16'h0078, 16'hFF88, 16'h4200, 16'hFFF8, 16'h0000};
   logic [8:0]  code[5] = '{9'h0F0, 9'h070, 9'h1A5, 9'h155, 9'h0FF};
   logic [15:0] rows[3] = '{16'hE200, 16'hE400, 16'hE600};
   initial forever #2.5 clk = ~clk;
   aps_decoder_path #(.STEP_SIZE(STEP), .FIFO_DEPTH(4)) u_dut (
      .CLK_IN(clk), .SYS_RST_IN(rst), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
      .BIT_STB_IN(stb), .RX_DATA_IN(rx), .BURST_VALID_IN(bval),
      .BURST_READY_OUT(brdy), .BURST_IN(bdat), .DAC_DATA_OUT(dac),
      .DAC_VALID_OUT(dval)
   );
   aps_burst_src u_src (
      .clk_in(clk), .ready_in(brdy), .valid_out(bval), .data_out(bdat)
   );
   task automatic compare(input string n, input logic [15:0] e,
                          input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : compare
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      rq.push_back(e);
      req <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask : rd
   // The host only switches paths with the decoder held off.
   task automatic mode(input logic [15:0] c);
      wr(aps_pkg::ADDR_INT_CTRL, 16'h0000);
      wr(aps_pkg::ADDR_PATH_CFG, c);
      wr(aps_pkg::ADDR_INT_CTRL, 16'h0008);
      est = 16'h0000;
   endtask : mode
   // how: 0 no expectation, 1 estimator plus add, 2 add alone.
   task automatic step(input logic p, input logic eb, input int how,
                       input logic [15:0] add);
      rx  <= p;
      stb <= 1'b1;
      est = eb ? est + STEP : est - STEP;
      @(posedge clk);
      stb <= 1'b0;
      if (how != 0)
         dq.push_back(how == 2 ? add : est + add);
      @(posedge clk);
   endtask : step
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   always @(posedge clk)
   begin
      if (dval === 1'b1 && dq.size() != 0)
         compare("dac", dq.pop_front(), dac);
      if (seen && rq.size() != 0)
         compare("reg", rq.pop_front(), rdata);
      seen <= req.rd;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize();
   end
   initial
   begin
      void'($urandom(22327));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(aps_pkg::ADDR_PATH_CFG, aps_pkg::RST_PATH_CFG);
      rd(aps_pkg::ADDR_INT_CTRL, 16'h0000);
      wr(aps_pkg::ADDR_PATH_CFG, 16'hB5A6);
      rd(aps_pkg::ADDR_PATH_CFG, 16'hB5A6);
      wr(aps_pkg::ADDR_PCM_OUT, 16'h5A5A);
      rd(aps_pkg::ADDR_PCM_OUT, 16'h0000);
      rd(8'h3C, 16'h0000);
      $display("test registers done");
      mode(16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         step(!i[0], !i[0], 1, 16'h0000);
         if (i == 3)
            rd(aps_pkg::ADDR_PCM_OUT, 16'h0000);
      end
      rd(aps_pkg::ADDR_PCM_OUT, 16'h0080);
      mode(16'h8000);
      for (int i = 0; i < 4; i++)
         step(i < 2, i < 2, 1, 16'h0000);
      rd(aps_pkg::ADDR_PCM_OUT, 16'h0100);
      rd(aps_pkg::ADDR_READBACK, 16'h0000);
      $display("test rates done");
      mode(16'h0000);
      for (int i = 0; i < 40; i++)
      begin
         b = 1'($urandom());
         step(b, b, 1, 16'h0000);
      end
      mode(16'h0800);
      wr(aps_pkg::ADDR_FEED, FW);
      for (int i = 15; i >= 0; i--)
         step(!FW[i], FW[i], 1, 16'h0000);
      // Digital feedback needs no analog path, so it may be off.
      mode(16'hF000);
      wr(aps_pkg::ADDR_PCM_IN, 16'h0300);
      for (int k = 0; k < 8; k++)
         step(1'b0, FBK[k], 1, 16'h0000);
      rd(aps_pkg::ADDR_READBACK, 16'h000E);
      $display("test sources done");
      for (int r = 0; r < 3; r++)
      begin
         mode(rows[r]);
         wr(aps_pkg::ADDR_PCM_IN, 16'h1234);
         for (int k = 1; k <= 8; k++)
            step(1'b1, 1'b1, r == 2 ? 1 : (k > 4 ? r + 1 : 0),
                 r == 2 ? 16'h0000 : 16'h1234);
      end
      $display("test outputs done");
      mode(16'hC200);
      for (int i = 0; i < 5; i++)
         u_src.q.push_back(aps_pkg::aps_burst_t'(code[i]));
      repeat (10) @(posedge clk);
      compare("ready", 16'h0000, {15'h0000, brdy});
      for (int k = 1; k <= 20; k++)
         step(1'b1, 1'b1, k > 4 ? 1 : 0,
              k > 4 ? lin[(k - 1) / 4 - 1] : 16'h0000);
      repeat (4) @(posedge clk);
      compare("ready", 16'h0001, {15'h0000, brdy});
      $display("test burst done");
      summarize();
   end
endmodule : testbench
`default_nettype wire
